// File: hbdc_pkg.sv
// Package with constants and carrier types for the half-bridge control block
// Functional notes
// (RULE1) Enable low floats output; else follow input
// (RULE2) Brushed motor: both enabled, input pairs
// (RULE3) Solenoid: low energises, high brakes, off coasts
// (RULE4) Compensation pads each edge to target delay
// (RULE5) Controller sets target to delay plus deadtime
// (RULE6) Regulator-off bit disables buck regulator
// (RULE7) Internal pulse at 20 or 40 kHz
// (RULE8) Mid-rail level disables limit; lower sets limit
// (RULE9) Limiting only in current-limit PWM modes
// (RULE10) High-side sourced load gets no limiting
// (RULE11) Compensation enable resets to disabled
// (RULE12) Target code maps to 0.4..3.2 us steps
// (RULE13) Longer of internal and controller dead time
// (RULE14) Over-limit turns high side off rest of period
// (RULE15) Reset restores all configuration defaults
package hbdc_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int PERIOD_NS = 10;
  localparam int STEP_NS = 200;
  localparam int STEP_CYC = STEP_NS / PERIOD_NS;
  localparam int BASE_NS = 200;
  localparam int BASE_CYC = BASE_NS / PERIOD_NS;
  localparam int DEAD_NS = 100;
  localparam int DEAD_CYC = (DEAD_NS + PERIOD_NS - 1) / PERIOD_NS;
  localparam int PULSE20_HZ = 20000;
  localparam int PULSE40_HZ = 40000;
  localparam int P20_CYC = CLK_MHZ * 1000000 / PULSE20_HZ;
  localparam int P40_CYC = CLK_MHZ * 1000000 / PULSE40_HZ;
  localparam int PULSE_ON_CYC = 50;
  localparam int CNT_W = 13;
  // ==========================================================
  // Reset values
  localparam logic RST_COMP_ON = 1'h0;
  localparam logic [3:0] RST_GOAL = 4'h0;
  localparam logic RST_REG_OFF = 1'h0;
  localparam logic RST_SEL40 = 1'h0;
  // ==========================================================
  // Modes
  typedef enum logic [1:0] {
    MODE_6X, MODE_3X, MODE_6X_LIM, MODE_3X_LIM
  } hbdc_mode_type;
  // Per-phase controller command
  typedef struct packed {
    logic level;
    logic on;
  } hbdc_cmd_type;
  // Per-phase pin drive
  typedef struct packed {
    logic hiOn;
    logic loOn;
    logic pinOut;
    logic pinOe;
  } hbdc_drv_type;
  // Configuration bits
  typedef struct packed {
    logic skewCompOn;
    logic [3:0] skewGoal;
    logic regulatorOff;
    logic sel40k;
    hbdc_mode_type mode;
  } hbdc_cfg_type;
endpackage

// File: hbdc_phase.sv
// One half-bridge phase: dead time, delay pad and limit gating
`timescale 1ns/100ps
module hbdc_phase
  import hbdc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire hbdc_pkg::hbdc_cmd_type cmd,
  input wire logic compOn,
  input wire logic [8:0] padCyc,
  input wire logic limitOn,
  input wire logic overLimit,
  input wire logic periodStart,
  output hbdc_pkg::hbdc_drv_type drv
);
  // ==========================================================
  // Delayed command after compensation pad
  hbdc_cmd_type held_ff;
  hbdc_cmd_type cmdLast_ff;
  logic [8:0] padCnt_ff; // Longest pad is 320 cycles, so nine bits
  logic chop_ff;
  logic [5:0] deadCnt_ff;
  logic wantHi;
  logic wantLo;
  // Pad every edge by the programmed extra delay
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      held_ff <= '0;
      cmdLast_ff <= '0;
      padCnt_ff <= 9'h000;
    end
    else
    begin
      cmdLast_ff <= cmd;
      if (cmd != cmdLast_ff)
        padCnt_ff <= compOn ? padCyc : 9'h000; // RULE4
      else if (padCnt_ff != 9'h000)
        padCnt_ff <= padCnt_ff - 9'h001;
      // Same total delay whichever way current flows
      if (cmd == cmdLast_ff && padCnt_ff == 9'h000)
        held_ff <= cmd; // RULE4
    end
  end
  // Chop latch cleared only at period start
  always_ff @(posedge mclk)
  begin
    if (rst)
      chop_ff <= 1'h0;
    else if (limitOn && overLimit && held_ff.on && held_ff.level)
      chop_ff <= 1'h1; // RULE14
    else if (periodStart)
      chop_ff <= 1'h0;
  end
  // Desired switch states from the truth table
  always_comb
  begin
    wantHi = held_ff.on && held_ff.level && !chop_ff; // RULE1 RULE14
    wantLo = held_ff.on && !held_ff.level; // RULE1
  end
  // Dead time: longer of internal gap and controller gap wins
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      drv <= '0;
      deadCnt_ff <= 6'h00;
    end
    else
    begin
      drv.pinOe <= held_ff.on; // RULE1
      drv.pinOut <= held_ff.on && held_ff.level && !chop_ff;
      if ((drv.hiOn && !wantHi) || (drv.loOn && !wantLo))
      begin
        drv.hiOn <= drv.hiOn && wantHi;
        drv.loOn <= drv.loOn && wantLo;
        deadCnt_ff <= 6'(DEAD_CYC); // RULE13
      end
      else if (deadCnt_ff != 6'h00)
        deadCnt_ff <= deadCnt_ff - 6'h01;
      else
      begin
        drv.hiOn <= wantHi && !drv.loOn; // RULE13
        drv.loOn <= wantLo && !drv.hiOn;
      end
    end
  end
  // ==========================================================
  // Checks
  AST_NO_SHOOT: assert property (@(posedge mclk) disable iff (rst) // RULE13
    !(drv.hiOn && drv.loOn))
    else $error("both switches on");
  AST_FLOAT: assert property (@(posedge mclk) disable iff (rst) // RULE1
    !held_ff.on |=> !drv.pinOe)
    else $error("output not floated");
  AST_CHOP: assert property (@(posedge mclk) disable iff (rst) // RULE14
    chop_ff && !periodStart |=> chop_ff && !wantHi)
    else $error("chop released early");
  AST_DEAD: assert property (@(posedge mclk) disable iff (rst) // RULE13
    $fell(drv.hiOn) |-> !drv.loOn [*2])
    else $error("dead time short");
  COV_CHOP: cover property (@(posedge mclk) $rose(chop_ff));
  COV_LOW: cover property (@(posedge mclk) $rose(drv.loOn));
endmodule // hbdc_phase

// File: hbdc_top.sv
// Half-bridge drive control top: config, pulse generator, three phases
`timescale 1ns/100ps
module hbdc_top
  import hbdc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire hbdc_pkg::hbdc_cmd_type phaseAIn,
  input wire hbdc_pkg::hbdc_cmd_type phaseBIn,
  input wire hbdc_pkg::hbdc_cmd_type phaseCIn,
  input wire hbdc_pkg::hbdc_cfg_type cfgIn,
  input wire logic cfgLoad,
  input wire logic serialVariant,
  input wire logic limitDisabled,
  input wire logic [2:0] overLimit,
  input wire logic [2:0] hsSourced,
  output hbdc_pkg::hbdc_drv_type phaseAOut,
  output hbdc_pkg::hbdc_drv_type phaseBOut,
  output hbdc_pkg::hbdc_drv_type phaseCOut,
  output logic regulatorOff,
  output logic [2:0] senseOn,
  output logic pulseActive
);
  // ==========================================================
  // Configuration
  hbdc_cfg_type cfg_ff;
  logic [CNT_W-1:0] perCnt_ff;
  logic periodStart;
  logic [8:0] padCyc; // Up to 320 cycles at code 15
  logic limitOn;
  logic [2:0] full_ff;
  hbdc_cmd_type [2:0] cmds;
  hbdc_drv_type [2:0] drvs;
  // Configuration latch, defaults on reset
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cfg_ff.skewCompOn <= RST_COMP_ON; // RULE11 RULE15
      cfg_ff.skewGoal <= RST_GOAL; // RULE12 RULE15
      cfg_ff.regulatorOff <= RST_REG_OFF;
      cfg_ff.sel40k <= RST_SEL40;
      cfg_ff.mode <= MODE_6X;
    end
    else if (cfgLoad)
    begin
      cfg_ff <= cfgIn;
      // Pin variant can neither disable buck nor program target
      if (!serialVariant)
      begin
        cfg_ff.regulatorOff <= 1'h0; // RULE6
        cfg_ff.skewGoal <= RST_GOAL; // RULE5
      end
    end
  end
  // Regulator disable output
  always_ff @(posedge mclk)
  begin
    if (rst)
      regulatorOff <= 1'h0;
    else
      regulatorOff <= cfg_ff.regulatorOff; // RULE6
  end
  // Code 0 means no pad; else base plus steps, 0.4..3.2 us
  always_comb
  begin
    if (cfg_ff.skewGoal == 4'h0)
      padCyc = 9'h000; // RULE12
    else
      padCyc = 9'(BASE_CYC) + 9'(cfg_ff.skewGoal) * 9'(STEP_CYC);
  end
  // Limiting only in limit modes and not at mid-rail
  always_comb
  begin
    limitOn = (cfg_ff.mode == MODE_6X_LIM || cfg_ff.mode == MODE_3X_LIM)
      && !limitDisabled; // RULE8 RULE9
  end
  // ==========================================================
  // Internal pulse timer for full duty sampling
  always_ff @(posedge mclk)
  begin
    if (rst)
      perCnt_ff <= '0;
    else if (periodStart)
      perCnt_ff <= '0;
    else
      perCnt_ff <= perCnt_ff + CNT_W'(1);
  end
  assign periodStart = perCnt_ff ==
    (cfg_ff.sel40k ? CNT_W'(P40_CYC - 1) : CNT_W'(P20_CYC - 1)); // RULE7
  assign cmds = {phaseCIn, phaseBIn, phaseAIn};
  // A phase still high at a period start is at full duty until it drops
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      full_ff <= 3'h0;
      pulseActive <= 1'h0;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
        if (!(cmds[i].on && cmds[i].level))
          full_ff[i] <= 1'h0;
        else if (periodStart)
          full_ff[i] <= 1'h1;
      pulseActive <= limitOn && (|full_ff); // RULE7
    end
  end
  // Sense feedback only when low side carries the current
  always_ff @(posedge mclk)
  begin
    if (rst)
      senseOn <= 3'h0;
    else
      for (int i = 0; i < 3; i++)
        senseOn[i] <= drvs[i].loOn && !hsSourced[i]; // RULE9 RULE10
  end
  // ==========================================================
  // Phase instances
  for (genvar g = 0; g < 3; g++)
  begin : gPhase
    hbdc_phase uPhase (
      .mclk(mclk),
      .rst(rst),
      .cmd(cmds[g]),
      .compOn(cfg_ff.skewCompOn),
      .padCyc(padCyc),
      .limitOn(limitOn && !hsSourced[g]), // RULE10
      .overLimit(overLimit[g]),
      .periodStart(periodStart),
      .drv(drvs[g])
    );
  end
  assign phaseAOut = drvs[0];
  assign phaseBOut = drvs[1];
  assign phaseCOut = drvs[2];
  // ==========================================================
  // Checks
  AST_REG_PIN: assert property (@(posedge mclk) disable iff (rst) // RULE6
    cfgLoad && !serialVariant |=> ##1 !regulatorOff)
    else $error("pin variant disabled buck");
  // Serial variant must really honour the regulator-off bit
  AST_REG_SER: assert property (@(posedge mclk) disable iff (rst) // RULE6
    cfgLoad && serialVariant && cfgIn.regulatorOff |=> ##1 regulatorOff)
    else $error("serial variant kept buck on");
  AST_NO_LIMIT: assert property (@(posedge mclk) disable iff (rst) // RULE9
    cfg_ff.mode == MODE_6X |-> !limitOn)
    else $error("limit in plain mode");
  // Code 15 is 3.2 us, i.e. 320 cycles of pad
  AST_PAD: assert property (@(posedge mclk) disable iff (rst) // RULE12
    cfg_ff.skewGoal == 4'hF |-> padCyc == 9'h140)
    else $error("target 3.2 us wrong");
  AST_MID: assert property (@(posedge mclk) disable iff (rst) // RULE8
    limitDisabled |-> !limitOn)
    else $error("limit at mid rail");
  AST_RST: assert property (@(posedge mclk) // RULE11 RULE15
    rst |=> !cfg_ff.skewCompOn && cfg_ff.skewGoal == 4'h0)
    else $error("reset value wrong");
  // Outputs come back quiet one edge into reset
  AST_RST_OUT: assert property (@(posedge mclk) // RULE15
    rst |=> !regulatorOff && !pulseActive && senseOn == 3'h0)
    else $error("outputs not cleared by reset");
  // No internal pulse unless limiting is live
  AST_PULSE_OFF: assert property (@(posedge mclk) disable iff (rst) // RULE9
    !limitOn |=> !pulseActive)
    else $error("pulse outside limit mode");
  // Ground-tied loads never report sense feedback
  AST_SENSE_HS: assert property (@(posedge mclk) disable iff (rst) // RULE10
    |hsSourced |=> (senseOn & $past(hsSourced)) == 3'h0)
    else $error("sense on sourced phase");
  COV_PULSE: cover property (@(posedge mclk) $rose(pulseActive));
  COV_SENSE: cover property (@(posedge mclk) $rose(senseOn[0]));
  COV_COMP: cover property (@(posedge mclk) cfg_ff.skewCompOn);
endmodule // hbdc_top

// File: hbdc_ctrl_model.sv
// Controller model that drives the three phase commands
`timescale 1ns/100ps
module hbdc_ctrl_model
(
  input wire logic mclk,
  input wire logic rst,
  output hbdc_pkg::hbdc_cmd_type phaseAIn,
  output hbdc_pkg::hbdc_cmd_type phaseBIn,
  output hbdc_pkg::hbdc_cmd_type phaseCIn
);
  import hbdc_pkg::*;
  // ==========================================================
  // Expected pin views {oe,out} per phase, oldest first
  logic [5:0] expQ[$];
  logic [5:0] expLast; // Last view noted, so no change means no note
  initial
  begin
    {phaseAIn, phaseBIn, phaseCIn} = '0;
    expLast = '0;
  end
  // Reset empties the commands; the pins fall to zero as well
  always @(negedge mclk)
    if (rst)
    begin
      {phaseAIn, phaseBIn, phaseCIn} = '0;
      expLast = '0;
    end
  // ==========================================================
  // Drive a command word {A,B,C} after a falling edge, then hold
  task automatic apply(input logic [5:0] cmd, input int hold);
    logic [5:0] v;
    @(negedge mclk);
    {phaseAIn, phaseBIn, phaseCIn} = cmd;
    // Enable low floats the pin whatever the level says
    for (int i = 0; i < 3; i++)
      v[2*i +: 2] = {cmd[2*i], cmd[2*i] & cmd[2*i+1]};
    if (v !== expLast)
      expQ.push_back(v);
    expLast = v;
    repeat (hold) @(negedge mclk);
  endtask
endmodule // hbdc_ctrl_model

// File: hbdc_top_bench.sv
// Self-checking bench for the half-bridge drive control top
`timescale 1ns/100ps
module hbdc_top_bench;
  import hbdc_pkg::*;
  // ==========================================================
  // Design connections
  logic mclk, rst, cfgLoad, serialVariant, limitDisabled, regulatorOff;
  logic pulseActive;
  hbdc_cmd_type phaseAIn, phaseBIn, phaseCIn;
  hbdc_cfg_type cfgIn;
  logic [2:0] overLimit, hsSourced, senseOn;
  hbdc_drv_type phaseAOut, phaseBOut, phaseCOut;
  int mismatches = 0;
  int n_tests = 0;
  logic [15:0] seed; // Random source, fixed start
  logic [5:0] cur, last; // Pin view now and at the previous edge
  hbdc_top dut (.mclk(mclk), .rst(rst), .phaseAIn(phaseAIn),
    .phaseBIn(phaseBIn), .phaseCIn(phaseCIn), .cfgIn(cfgIn),
    .cfgLoad(cfgLoad), .serialVariant(serialVariant),
    .limitDisabled(limitDisabled), .overLimit(overLimit),
    .hsSourced(hsSourced), .phaseAOut(phaseAOut), .phaseBOut(phaseBOut),
    .phaseCOut(phaseCOut), .regulatorOff(regulatorOff),
    .senseOn(senseOn), .pulseActive(pulseActive));
  hbdc_ctrl_model ctrl (.mclk(mclk), .rst(rst), .phaseAIn(phaseAIn),
    .phaseBIn(phaseBIn), .phaseCIn(phaseCIn));
  initial
  begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  // ==========================================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Floating pins hide the level, so it is masked by the enable
  function automatic logic [1:0] pv(input hbdc_drv_type d);
    return {d.pinOe, d.pinOe & d.pinOut};
  endfunction
  task automatic check(input string nm, input logic [16:0] e,
    input logic [16:0] s);
    n_tests++;
    if (e !== s)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out();
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic do_reset();
    @(negedge mclk);
    rst = 1;
    repeat (3) @(negedge mclk);
    rst = 0;
  endtask
  task automatic load_cfg(input hbdc_cfg_type c, input logic sv);
    @(negedge mclk);
    cfgIn = c;
    serialVariant = sv;
    cfgLoad = 1;
    @(negedge mclk);
    cfgLoad = 0;
    repeat (3) @(negedge mclk);
  endtask
  // ==========================================================
  // Monitor: every pin change takes the oldest note
  always @(posedge mclk)
  begin
    cur = {pv(phaseAOut), pv(phaseBOut), pv(phaseCOut)};
    if (rst)
      last = '0;
    else if (cur !== last)
      check("pins", ctrl.expQ.size() > 0 ? ctrl.expQ.pop_front() : 'x,
        cur);
    if (!rst)
      last = cur;
  end
  // ==========================================================
  // Main sequence
  logic [5:0] rows[8] = '{6'h34, 6'h1C, 6'h14, 6'h3C, 6'h28, 6'h01,
    6'h03, 6'h02};
  logic [8:0] lat[6] = '{9'h00F, 9'h11F, 9'h13F, 9'h13E, 9'h101, 9'h0FF};
  logic [5:0] chop[5] = '{6'h09, 6'h0D, 6'h0A, 6'h18, 6'h00};
  initial
  begin
    int n, e, tg;
    logic [5:0] c0;
    rst = 1;
    {cfgIn, cfgLoad, serialVariant, limitDisabled} = '0;
    {overLimit, hsSourced} = '0;
    seed = 16'h6598;
    do_reset();
    check("rstOut", '0, {phaseAOut, phaseBOut, phaseCOut, regulatorOff,
      senseOn, pulseActive});
    foreach (rows[i]) ctrl.apply(rows[i], 8);
    repeat (8)
    begin
      seed = lfsr(seed);
      ctrl.apply(seed[5:0], 8);
    end
    ctrl.apply(6'h10, 8);
    check("drained", 0, ctrl.expQ.size());
    // Latency {sv,comp,code}; 0xFF marks a step that skips the load and keeps the config already loaded
    tg = 0;
    foreach (lat[i])
    begin
      if (lat[i] != 9'h0FF)
        load_cfg({lat[i][4], lat[i][3:0], 1'b0, 1'b0, MODE_6X},
          lat[i][8]);
      e = 3;
      if (lat[i] != 9'h0FF && lat[i][4] && lat[i][8] && lat[i][3:0] != 0)
        e += BASE_CYC + STEP_CYC * lat[i][3:0];
      c0 = cur;
      tg = 1 - tg;
      ctrl.apply(tg ? 6'h30 : 6'h10, 0);
      n = 0;
      while (cur === c0 && n < 400)
      begin
        @(negedge mclk);
        n++;
      end
      check("lat", e, (n >= e && n <= e + 1) ? e : n);
    end
    for (int s = 0; s < 2; s++)
    begin
      load_cfg({1'b0, 4'h0, 1'b1, 1'b0, MODE_6X}, s[0]);
      check("regOff", s[0], regulatorOff);
    end
    // Chop table {chops, lim mode, mode bit, limit off, grounded}
    foreach (chop[i])
    begin
      do_reset();
      load_cfg({1'b0, 4'h0, 1'b0, 1'b0, chop[i][3] ? (chop[i][2] ?
        MODE_3X_LIM : MODE_6X_LIM) : MODE_6X}, 1'b1);
      limitDisabled = chop[i][1];
      hsSourced[0] = chop[i][0];
      ctrl.apply(6'h30, 30);
      overLimit[0] = 1;
      // Chopping drops the driven level, so the pin view changes once
      if (chop[i][4])
        ctrl.expQ.push_back(6'h20);
      repeat (20) @(negedge mclk);
      e = chop[i][4] ? 0 : 1;
      check("hiOn", e, phaseAOut.hiOn);
      overLimit[0] = 0;
    end
    // Full duty in limit mode: pulse at 40 kHz, 2500 cycles a period
    do_reset();
    load_cfg({1'b0, 4'h0, 1'b0, 1'b1, MODE_6X_LIM}, 1'b1);
    limitDisabled = 0;
    hsSourced = '0;
    ctrl.apply(6'h30, 2600);
    check("pulse", 1, pulseActive);
    ctrl.apply(6'h10, 20);
    check("pulse", 0, pulseActive);
    check("sense", 3'h1, senseOn);
    hsSourced[0] = 1;
    repeat (2) @(negedge mclk);
    check("sense", 3'h0, senseOn);
    close_out();
  end
endmodule // hbdc_top_bench
